/* shared/drh_pkg.sv */
// package: timing constants, states and helpers for the drive reset/diag handshake
package drh_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned CLK_PERIOD_NS = 5;
   // one millisecond tick from the system clock
   localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
   localparam logic [17:0] MS_TC         = 18'(MS_CYCLES - 1);
   // times in their own units
   localparam int unsigned RST_PULSE_US  = 25;
   localparam int unsigned BSY_MAX_NS    = 400;
   localparam int unsigned BSY_CYCLES    = BSY_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned REL_MAX_MS    = 1;
   localparam int unsigned PRES_WIN_MS   = 450;
   localparam int unsigned SLV_ANN_MS    = 400;
   localparam int unsigned DIAG_RST_S    = 30;
   localparam int unsigned HOLD_RST_S    = 31;
   localparam int unsigned DIAG_CMD_S    = 5;
   localparam int unsigned HOLD_CMD_S    = 6;
   // ms counts (15 bits reach 31 s)
   localparam logic [14:0] PRES_WIN_T    = 15'(PRES_WIN_MS);
   localparam logic [14:0] HOLD_RST_T    = 15'(HOLD_RST_S * 1000);
   localparam logic [14:0] HOLD_CMD_T    = 15'(HOLD_CMD_S * 1000);
   localparam logic [14:0] DIAG_RST_T    = 15'(DIAG_RST_S * 1000);
   localparam logic [14:0] DIAG_CMD_T    = 15'(DIAG_CMD_S * 1000);
   localparam logic [14:0] REL_T         = 15'(REL_MAX_MS);

   typedef enum logic [2:0] {
      DRH_IDLE  = 3'b000,
      DRH_REL   = 3'b001,
      DRH_PRES  = 3'b011,
      DRH_WDIAG = 3'b010,
      DRH_DONE  = 3'b110
   } drh_state_e;

   function automatic logic [14:0] drh_min15(input logic [14:0] a, input logic [14:0] b);
      drh_min15 = (a < b) ? a : b;
   endfunction
endpackage

/* shared/drh_tick_if.sv */
// interface: millisecond timebase between the sequencer and its timer
interface drh_tick_if;
   logic        restart;
   logic        ms_tick;
   logic [14:0] ms_cnt;
   modport ctl (output restart, input ms_tick, input ms_cnt);
   modport tmr (input restart, output ms_tick, output ms_cnt);
endinterface

/* verification/drh_slave_model.sv */
// behavioural model of the companion slave drive on the shared cable
module drh_slave_model #(
   parameter int PRES_DLY = 20,  // cycles from go to presence, far inside the announce limit
   parameter int DIAG_DLY = 60   // cycles from go to diag pass
) (
   input  wire logic clk,          // system clock
   input  wire logic rst,          // reset, active high
   input  wire logic go,           // slave out of reset, low restarts it
   input  wire logic diag_pass,    // slave diagnostics result
   output logic      dasp_n_oe_n,  // presence drive, low = pull line
   output logic      pdiag_n_oe_n  // diag drive, low = pull line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   wire         diag_low;
   // saturate so a long run never wraps back into the announce phase
   assign nxt_cnt  = !go ? 16'h0000 : (cnt_ff == 16'hFFFF) ? cnt_ff : cnt_ff + 16'h0001;
   assign diag_low = go && diag_pass && (cnt_ff >= 16'(DIAG_DLY));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   // presence is the complement of diag once announced
   assign dasp_n_oe_n  = !(go && !diag_low && (cnt_ff >= 16'(PRES_DLY)));
   assign pdiag_n_oe_n = !diag_low;
endmodule

/* verification/tb_drh_reset_diag.sv */
// self-checking bench for the reset and diagnostic handshake
module tb_drh_reset_diag;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, is_slave = 1'b0, hw_reset_n = 1'b1;
   logic sw_reset = 1'b0, diag_cmd = 1'b0, host_cmd = 1'b0, self_test_ok = 1'b1;
   logic p_go = 1'b0, p_pass = 1'b1;
   logic dasp_n_out, dasp_n_oe_n, pdiag_n_out, pdiag_n_oe_n, busy;
   logic slave_present, slave_diag_ok, seq_done, p_dasp_oe_n, p_pdiag_oe_n;
   wire  dasp_line, pdiag_line;
   int   errors = 0;
   int   n_checks = 0;
   // shortened millisecond so the presence window and diag release fit in one run
   localparam int unsigned MS_CYC_TB = 20;
   // pulled-up open-drain lines: low while any party drives
   assign dasp_line  = dasp_n_oe_n & p_dasp_oe_n;
   assign pdiag_line = pdiag_n_oe_n & p_pdiag_oe_n;
   always #2.5 clk = ~clk;
   drh_reset_diag #(.MS_CYC(MS_CYC_TB)) dut (.clk(clk), .rst(rst), .is_slave(is_slave),
      .hw_reset_n(hw_reset_n),
      .sw_reset(sw_reset), .diag_cmd(diag_cmd), .host_cmd(host_cmd),
      .self_test_ok(self_test_ok), .dasp_n_in(dasp_line), .dasp_n_out(dasp_n_out),
      .dasp_n_oe_n(dasp_n_oe_n), .pdiag_n_in(pdiag_line), .pdiag_n_out(pdiag_n_out),
      .pdiag_n_oe_n(pdiag_n_oe_n), .busy(busy), .slave_present(slave_present),
      .slave_diag_ok(slave_diag_ok), .seq_done(seq_done));
   drh_slave_model part (.clk(clk), .rst(rst), .go(p_go), .diag_pass(p_pass),
      .dasp_n_oe_n(p_dasp_oe_n), .pdiag_n_oe_n(p_pdiag_oe_n));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_done(input int lim);
      for (int i = 0; i < lim && seq_done !== 1'b1; i++) @(posedge clk);
      #1;
   endtask
   task automatic por(input logic slave, input logic with_part);
      @(posedge clk);
      rst <= 1'b1;
      is_slave <= slave;
      p_go <= 1'b0;
      cyc(4);
      #1;
      check("busy in reset", busy, 1);
      check("oe in reset", {dasp_n_oe_n, pdiag_n_oe_n, seq_done}, 3'h6);
      check("drive values", {dasp_n_out, pdiag_n_out}, 2'h0);
      @(posedge clk);
      rst <= 1'b0;
      p_go <= with_part;
   endtask
   task automatic t_por_master;
      por(1'b0, 1'b1);
      wait_done(2000);
      check("slave_present", slave_present, 1);
      check("slave_diag_ok", slave_diag_ok, 1);
      check("busy after done", busy, 0);
      $display("test por_master done");
   endtask
   task automatic t_no_slave;
      por(1'b0, 1'b0);
      cyc(drh_pkg::PRES_WIN_MS * MS_CYC_TB - 20);
      #1;
      check("busy in window", {busy, seq_done}, 2'h2);
      wait_done(100);
      check("no slave done", {seq_done, slave_present, slave_diag_ok}, 3'h4);
      check("no slave busy", busy, 0);
      $display("test no_slave done");
   endtask
   task automatic t_short_pulse;
      @(posedge clk);
      hw_reset_n <= 1'b0;
      cyc(1000);
      hw_reset_n <= 1'b1;
      cyc(100);
      #1;
      check("busy after short pulse", busy, 0);
      $display("test short_pulse done");
   endtask
   task automatic t_hw_reset;
      int n;
      @(posedge clk);
      hw_reset_n <= 1'b0;
      p_go <= 1'b0;
      cyc(drh_pkg::RST_PULSE_CYC + 10);
      hw_reset_n <= 1'b1;
      for (n = 0; n < 80 && busy !== 1'b1; n++) @(posedge clk);
      #1;
      check("busy after hw release", busy, 1);
      check("presence released", dasp_n_oe_n, 1);
      @(posedge clk);
      p_go <= 1'b1;
      wait_done(2000);
      check("hw slave_present", slave_present, 1);
      check("hw slave_diag_ok", slave_diag_ok, 1);
      $display("test hw_reset done");
   endtask
   // software reset and diagnostic command share one walk
   task automatic t_cmd_reset(input logic use_diag);
      @(posedge clk);
      sw_reset <= !use_diag;
      diag_cmd <= use_diag;
      p_go <= 1'b0;
      @(posedge clk);
      sw_reset <= 1'b0;
      diag_cmd <= 1'b0;
      p_go <= 1'b1;
      cyc(40);
      #1;
      check("busy while slave announces", busy, 1);
      wait_done(2000);
      check("cmd slave_diag_ok", slave_diag_ok, 1);
      check("cmd busy", busy, 0);
      $display("test cmd_reset %0d done", use_diag);
   endtask
   task automatic t_slave;
      por(1'b1, 1'b0);
      cyc(5);
      #1;
      check("slave presence", dasp_n_oe_n, 0);
      check("slave diag free", pdiag_n_oe_n, 1);
      check("slave busy", busy, 1);
      @(posedge clk);
      host_cmd <= 1'b1;
      @(posedge clk);
      host_cmd <= 1'b0;
      cyc(3);
      #1;
      check("presence after cmd", dasp_n_oe_n, 1);
      cyc(2 * MS_CYC_TB);
      #1;
      check("slave diag shown", pdiag_n_oe_n, 0);
      check("presence off with diag", dasp_n_oe_n, 1);
      $display("test slave done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      print_verdict();
   end
   initial begin
      t_por_master();
      t_no_slave();
      t_short_pulse();
      t_hw_reset();
      t_cmd_reset(1'b0);
      t_cmd_reset(1'b1);
      t_slave();
      print_verdict();
   end
endmodule

/* verilog/drh_ms_timer.sv */
// millisecond timer restarted by the sequencer
module drh_ms_timer #(
   parameter int unsigned MS_CYC = drh_pkg::MS_CYCLES // cycles per millisecond
) (
   input  wire logic clk,     // system clock
   input  wire logic rst,     // async reset, active high
   drh_tick_if.tmr   tk       // tick and elapsed ms
);
   logic [17:0] div_ff;
   logic [14:0] cnt_ff;
   logic        tick_ff;
   // terminal count follows the parameter so a shortened millisecond stays consistent
   localparam logic [17:0] TC = 18'(MS_CYC - 1);
   wire         wrap = (div_ff == TC);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_ff  <= 18'h00000;
         cnt_ff  <= 15'h0000;
         tick_ff <= 1'b0;
      end else if (tk.restart) begin
         div_ff  <= 18'h00000;
         cnt_ff  <= 15'h0000;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= wrap ? 18'h00000 : div_ff + 18'h00001;
         tick_ff <= wrap;
         if (wrap && cnt_ff != 15'h7FFF)
            cnt_ff <= cnt_ff + 15'h0001; // saturates, never wraps back to zero
      end
   end
   assign tk.ms_tick = tick_ff;
   assign tk.ms_cnt  = cnt_ff;

   AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (rst)
      $rose(tick_ff) && !tk.restart |=> !tick_ff [*3])
      else $error("ms tick repeated too soon");
endmodule

/* verilog/drh_reset_diag.sv */
// reset and diagnostic presence handshake for a two-drive cable
module drh_reset_diag #(
   parameter int unsigned MS_CYC = drh_pkg::MS_CYCLES // cycles per ms, lowered only to shorten tests
) (
   input  wire logic clk,           // system clock, 200 MHz
   input  wire logic rst,           // power-on reset, async, active high
   input  wire logic is_slave,      // strap: 1 = device 1
   input  wire logic hw_reset_n,    // cable reset pin, active low
   input  wire logic sw_reset,      // software reset pulse
   input  wire logic diag_cmd,      // diagnostic command pulse
   input  wire logic host_cmd,      // any other host command pulse
   input  wire logic self_test_ok,  // own diagnostics passed (level)
   input  wire logic dasp_n_in,     // presence line sense
   output logic      dasp_n_out,    // presence line drive value (0)
   output logic      dasp_n_oe_n,   // presence drive enable, low = drive
   input  wire logic pdiag_n_in,    // diag line sense
   output logic      pdiag_n_out,   // diag line drive value (0)
   output logic      pdiag_n_oe_n,  // diag drive enable, low = drive
   output logic      busy,          // busy status
   output logic      slave_present, // master: slave seen
   output logic      slave_diag_ok, // master: slave passed diag
   output logic      seq_done       // sequence finished
);
   drh_tick_if tk ();
   drh_ms_timer #(.MS_CYC(MS_CYC)) u_tmr (.clk(clk), .rst(rst), .tk(tk));

   // pin synchronisers
   logic [1:0] rstn_sy_ff, dasp_sy_ff, pdiag_sy_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rstn_sy_ff  <= 2'h3; // idle level of the pin, so no false release edge after reset
         dasp_sy_ff  <= 2'h3;
         pdiag_sy_ff <= 2'h3;
      end else begin
         rstn_sy_ff  <= {rstn_sy_ff[0], hw_reset_n};
         dasp_sy_ff  <= {dasp_sy_ff[0], dasp_n_in};
         pdiag_sy_ff <= {pdiag_sy_ff[0], pdiag_n_in};
      end
   end
   wire rstn_s  = rstn_sy_ff[1];
   wire dasp_a  = !dasp_sy_ff[1];
   wire pdiag_a = !pdiag_sy_ff[1];

   // hardware reset accepted only after a long enough low pulse
   logic [12:0] lowcnt_ff;
   logic        hw_arm_ff, rstn_d_ff, por_ff;
   wire         pulse_ok = (lowcnt_ff >= 13'(drh_pkg::RST_PULSE_CYC));
   wire         hw_rel   = rstn_s && !rstn_d_ff && hw_arm_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowcnt_ff <= 13'h0000;
         hw_arm_ff <= 1'b0;
         rstn_d_ff <= 1'b1;
         por_ff    <= 1'b1;
      end else begin
         rstn_d_ff <= rstn_s;
         por_ff    <= 1'b0;
         lowcnt_ff <= rstn_s ? 13'h0000 : (pulse_ok ? lowcnt_ff : lowcnt_ff + 13'h0001);
         hw_arm_ff <= rstn_s ? 1'b0 : pulse_ok;
      end
   end

   // kind of sequence in progress
   logic       slave_ff, kind_cmd_ff, kind_sw_ff, pres_up_ff;
   drh_pkg::drh_state_e st_ff, nxt_st;
   wire        restart = por_ff || hw_rel || sw_reset || diag_cmd;
   wire        sw_end  = sw_reset && slave_ff;
   wire [14:0] ms      = tk.ms_cnt;
   wire [14:0] diag_t  = kind_cmd_ff ? drh_pkg::DIAG_CMD_T : drh_pkg::DIAG_RST_T;
   wire [14:0] hold_t  = kind_cmd_ff ? drh_pkg::HOLD_CMD_T : drh_pkg::HOLD_RST_T;
   wire [14:0] ann_t   = drh_pkg::drh_min15(15'(drh_pkg::SLV_ANN_MS), drh_pkg::REL_T);
   assign tk.restart = restart;

   // slave: own diag result shown after release window, capped by the 30 s / 5 s bound
   wire diag_show = (ms >= drh_pkg::REL_T) && (self_test_ok || ms >= diag_t);
   wire diag_end  = ms >= (hold_t - 15'h0001);

   // master decisions
   wire m_seen  = (st_ff == drh_pkg::DRH_PRES) && dasp_a;
   wire m_tout  = (st_ff == drh_pkg::DRH_PRES) && (ms >= drh_pkg::PRES_WIN_T);
   wire m_ok    = (st_ff == drh_pkg::DRH_WDIAG) && pdiag_a;
   wire m_wtout = (st_ff == drh_pkg::DRH_WDIAG) && (ms >= hold_t);

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         drh_pkg::DRH_IDLE:  nxt_st = drh_pkg::DRH_IDLE;
         drh_pkg::DRH_REL: begin
            if (slave_ff)
               nxt_st = diag_end ? drh_pkg::DRH_DONE : drh_pkg::DRH_REL;
            else if (kind_cmd_ff || kind_sw_ff)
               nxt_st = slave_present ? drh_pkg::DRH_WDIAG : drh_pkg::DRH_DONE;
            else
               nxt_st = drh_pkg::DRH_PRES;
         end
         drh_pkg::DRH_PRES:  nxt_st = m_seen ? drh_pkg::DRH_WDIAG :
                                     (m_tout ? drh_pkg::DRH_DONE : drh_pkg::DRH_PRES);
         drh_pkg::DRH_WDIAG: nxt_st = (m_ok || m_wtout) ? drh_pkg::DRH_DONE : drh_pkg::DRH_WDIAG;
         drh_pkg::DRH_DONE:  nxt_st = drh_pkg::DRH_DONE;
         default:            nxt_st = drh_pkg::DRH_IDLE;
      endcase
   end

   // slave presence: low while diag still pending, and only after power-on or hardware reset
   wire pres_on  = slave_ff && pres_up_ff && !diag_show;
   wire nxt_dasp = slave_ff ? !pres_on : 1'b1;
   wire nxt_pdg  = slave_ff && (st_ff == drh_pkg::DRH_REL) && diag_show && !diag_end;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff         <= drh_pkg::DRH_IDLE;
         slave_ff      <= 1'b0;
         kind_cmd_ff   <= 1'b0;
         kind_sw_ff    <= 1'b0;
         pres_up_ff    <= 1'b0;
         busy          <= 1'b1;
         slave_present <= 1'b0;
         slave_diag_ok <= 1'b0;
         seq_done      <= 1'b0;
         dasp_n_oe_n   <= 1'b1;
         pdiag_n_oe_n  <= 1'b1;
      end else if (restart) begin
         st_ff        <= drh_pkg::DRH_REL;
         slave_ff     <= is_slave; // strap caught after reset release
         kind_cmd_ff  <= diag_cmd && !por_ff && !hw_rel;
         kind_sw_ff   <= sw_reset && !por_ff && !hw_rel;
         pres_up_ff   <= (por_ff || hw_rel) ? is_slave : 1'b0;
         busy         <= 1'b1;
         seq_done     <= 1'b0;
         dasp_n_oe_n  <= 1'b1;
         pdiag_n_oe_n <= 1'b1;
         if (por_ff || hw_rel) begin
            slave_present <= 1'b0;
            slave_diag_ok <= 1'b0;
         end else
            slave_diag_ok <= 1'b0;
      end else begin
         st_ff        <= nxt_st;
         dasp_n_oe_n  <= nxt_dasp;
         pdiag_n_oe_n <= !nxt_pdg;
         if (host_cmd || sw_end || (slave_ff && ms >= drh_pkg::HOLD_RST_T))
            pres_up_ff <= 1'b0;
         if (m_seen)
            slave_present <= 1'b1;
         if (m_ok)
            slave_diag_ok <= 1'b1;
         if (nxt_st == drh_pkg::DRH_DONE) begin
            seq_done <= 1'b1;
            busy     <= 1'b0;
         end
      end
   end
   assign dasp_n_out  = 1'b0;
   assign pdiag_n_out = 1'b0;
   wire unused_ann = |ann_t;

   AST_BSY_ON_REL: assert property (@(posedge clk) disable iff (rst)
      hw_rel |=> busy)
      else $error("busy not set after reset release");
   AST_BSY_HOLD: assert property (@(posedge clk) disable iff (rst)
      hw_rel |=> busy [*8])
      else $error("busy dropped during sequence start");
   AST_DRV_FREE: assert property (@(posedge clk) disable iff (rst)
      restart |=> dasp_n_oe_n && pdiag_n_oe_n)
      else $error("lines not released after reset");
   AST_PRES_NOT_SEEN: assert property (@(posedge clk) disable iff (rst)
      m_tout && !m_seen && !restart |=> !slave_present && seq_done)
      else $error("slave presence recorded without assertion");
   AST_PRES_SEEN: assert property (@(posedge clk) disable iff (rst)
      m_seen && !restart |=> slave_present && st_ff == drh_pkg::DRH_WDIAG)
      else $error("seen presence not taken");
   AST_HW_RECHECK: assert property (@(posedge clk) disable iff (rst)
      hw_rel && !is_slave |=> ##1 st_ff == drh_pkg::DRH_PRES)
      else $error("hardware reset skipped presence check");
   AST_SW_SKIP: assert property (@(posedge clk) disable iff (rst)
      sw_reset && !por_ff && !hw_rel && !is_slave |=> ##1 st_ff != drh_pkg::DRH_PRES)
      else $error("software reset ran presence check");
   AST_CMD_SKIP: assert property (@(posedge clk) disable iff (rst)
      diag_cmd && !sw_reset && !por_ff && !hw_rel && !is_slave
      |=> ##1 st_ff != drh_pkg::DRH_PRES)
      else $error("diagnostic command ran presence check");
   AST_COMPLEMENT: assert property (@(posedge clk) disable iff (rst)
      slave_ff && !dasp_n_oe_n |-> pdiag_n_oe_n)
      else $error("presence and diag driven together");
   AST_SLAVE_REL: assert property (@(posedge clk) disable iff (rst)
      host_cmd && !restart && slave_ff |=> ##1 dasp_n_oe_n)
      else $error("presence held after host command");
endmodule
